// File: logic/sfbo_top.sv
// Purpose: settings, buffer pointer and bit/byte ordering of a serial flash controller
// Assumes: APB slave on clk_sys; transaction strobes come from logic on the same clock
// Notes:   one wait state on every APB access; outputs registered
`timescale 1ns/1ps
`include "sfbo_consts.svh"
module sfbo_top (
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    input  wire logic                ce,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [31:0]         paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    input  wire logic                txn_start,
    input  wire logic                txn_done,
    input  wire logic                word_step,
    output logic                     busy,
    output logic      [31:0]         buf_addr,
    output sfbo_pkg::sfbo_cfg_type   active_cfg,
    input  wire logic                wr_valid_in,
    input  wire logic [31:0]         wr_word_in,
    output logic                     wr_valid_out,
    output logic      [31:0]         wr_word_out,
    input  wire logic                rd_valid_in,
    input  wire logic [31:0]         rd_word_in,
    output logic                     rd_valid_out,
    output logic      [31:0]         rd_word_out,
    input  wire logic                cmd_valid_in,
    input  wire logic [7:0]          cmd_byte_in,
    output logic                     cmd_valid_out,
    output logic      [7:0]          cmd_byte_out,
    input  wire logic                stat_valid_in,
    input  wire logic [7:0]          stat_byte_in,
    output logic                     stat_valid_out,
    output logic      [7:0]          stat_byte_out
);
    import sfbo_pkg::*;

    function automatic sfbo_reg_type reg_decode(input logic [31:0] a);
        sfbo_reg_type r;
        r = SFBO_REG_NONE;
        case (a)
            `SFBO_ADDR_BASE:     r = SFBO_REG_BASE;
            `SFBO_ADDR_SETTINGS: r = SFBO_REG_SETTINGS;
            `SFBO_ADDR_ACTIVE:   r = SFBO_REG_ACTIVE;
            default:             r = SFBO_REG_NONE;
        endcase
        return r;
    endfunction

    // ---------------- register bus
    sfbo_cfg_type settings;
    sfbo_cfg_type next_settings;
    logic [31:0]  base;
    logic [31:0]  next_base;
    logic [31:0]  next_prdata;
    logic         next_pready;
    logic         next_pslverr;
    sfbo_reg_type sel_reg;
    logic         access;
    logic         wr_commit;
    logic [15:0]  set_word;

    assign sel_reg   = reg_decode(paddr);
    assign access    = psel && penable;
    // writes land only at the edge where pready is seen high
    assign wr_commit = access && pready && pwrite && !pslverr;

    always_comb begin
        next_settings = settings;
        next_base     = base;
        next_prdata   = prdata;
        next_pready   = pready;
        next_pslverr  = pslverr;
        set_word      = {7'h00, settings};
        if (ce) begin
            next_pready = access && !pready;
            if (access && !pready) begin
                next_pslverr = (sel_reg == SFBO_REG_NONE);
                case (sel_reg)
                    SFBO_REG_BASE:     next_prdata = base;
                    SFBO_REG_SETTINGS: next_prdata = {16'h0000, set_word};
                    SFBO_REG_ACTIVE:   next_prdata = {busy, 22'h000000, active_cfg};
                    default:           next_prdata = 32'h00000000;
                endcase
            end else begin
                // error flag stands only with pready, never past the completing edge
                next_pslverr = 1'b0;
            end
            if (wr_commit && sel_reg == SFBO_REG_SETTINGS) begin
                // tuning field stored as written; software keeps it at reset value
                if (pstrb[0]) begin
                    next_settings[7:0] = pwdata[7:0];
                end
                if (pstrb[1]) begin
                    next_settings[8] = pwdata[`SFBO_BIT_WDATA_LSB];
                end
            end
            if (wr_commit && sel_reg == SFBO_REG_BASE) begin
                for (int i = 0; i < 4; i++) begin
                    if (pstrb[i]) begin
                        next_base[8*i +: 8] = pwdata[8*i +: 8];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            settings <= `SFBO_SETTINGS_RST;
            base     <= `SFBO_BASE_RST;
            prdata   <= 32'h00000000;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end else begin
            settings <= next_settings;
            base     <= next_base;
            prdata   <= next_prdata;
            pready   <= next_pready;
            pslverr  <= next_pslverr;
        end
    end

    // ---------------- transaction tracking
    sfbo_state_type state;
    sfbo_state_type next_state;
    sfbo_cfg_type   next_active_cfg;
    logic           next_busy;
    logic [31:0]    next_buf_addr;

    always_comb begin
        next_state      = state;
        next_active_cfg = active_cfg;
        next_buf_addr   = buf_addr;
        if (ce) begin
            case (state)
                SFBO_IDLE: begin
                    if (txn_start) begin
                        next_active_cfg = settings;
                        next_buf_addr   = base;
                        next_state      = SFBO_ACTIVE;
                    end
                end
                SFBO_ACTIVE: begin
                    // register writes mid-transfer wait for the next start
                    if (word_step) begin
                        next_buf_addr = buf_addr + `SFBO_WORD_STEP;
                    end
                    if (txn_done) begin
                        next_state = SFBO_IDLE;
                    end
                end
                default: begin
                    next_state = SFBO_IDLE;
                end
            endcase
        end
        next_busy = (next_state == SFBO_ACTIVE);
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state      <= SFBO_IDLE;
            active_cfg <= `SFBO_SETTINGS_RST;
            busy       <= 1'b0;
            buf_addr   <= `SFBO_BASE_RST;
        end else begin
            state      <= next_state;
            active_cfg <= next_active_cfg;
            busy       <= next_busy;
            buf_addr   <= next_buf_addr;
        end
    end

    // ---------------- data ordering
    sfbo_word_if wr_if ();
    sfbo_word_if rd_if ();

    // shifters always send bit 7 of byte 31:24 first, so ordering is fixed here
    assign wr_if.word_in = wr_word_in;
    assign wr_if.flip    = active_cfg.wdata_lsb_first;
    assign wr_if.swap    = active_cfg.byte_order_select;
    assign rd_if.word_in = rd_word_in;
    assign rd_if.flip    = active_cfg.rdata_flip;
    assign rd_if.swap    = active_cfg.byte_order_select;

    sfbo_lane u_wr_lane (
        .wd (wr_if.lane)
    );

    sfbo_lane u_rd_lane (
        .wd (rd_if.lane)
    );

    logic        next_wr_valid_out;
    logic [31:0] next_wr_word_out;
    logic        next_rd_valid_out;
    logic [31:0] next_rd_word_out;
    logic        next_cmd_valid_out;
    logic [7:0]  next_cmd_byte_out;
    logic        next_stat_valid_out;
    logic [7:0]  next_stat_byte_out;

    always_comb begin
        next_wr_valid_out   = wr_valid_out;
        next_wr_word_out    = wr_word_out;
        next_rd_valid_out   = rd_valid_out;
        next_rd_word_out    = rd_word_out;
        next_cmd_valid_out  = cmd_valid_out;
        next_cmd_byte_out   = cmd_byte_out;
        next_stat_valid_out = stat_valid_out;
        next_stat_byte_out  = stat_byte_out;
        if (ce) begin
            next_wr_valid_out   = wr_valid_in;
            next_rd_valid_out   = rd_valid_in;
            next_cmd_valid_out  = cmd_valid_in;
            next_stat_valid_out = stat_valid_in;
            if (wr_valid_in) begin
                next_wr_word_out = wr_if.word_out;
            end
            if (rd_valid_in) begin
                next_rd_word_out = rd_if.word_out;
            end
            if (cmd_valid_in) begin
                next_cmd_byte_out = active_cfg.cmd_lsb_first ?
                                    sfbo_rev8(cmd_byte_in) : cmd_byte_in;
            end
            if (stat_valid_in) begin
                next_stat_byte_out = active_cfg.status_byte_bit_flip ?
                                     sfbo_rev8(stat_byte_in) : stat_byte_in;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_valid_out   <= 1'b0;
            wr_word_out    <= 32'h00000000;
            rd_valid_out   <= 1'b0;
            rd_word_out    <= 32'h00000000;
            cmd_valid_out  <= 1'b0;
            cmd_byte_out   <= 8'h00;
            stat_valid_out <= 1'b0;
            stat_byte_out  <= 8'h00;
        end else begin
            wr_valid_out   <= next_wr_valid_out;
            wr_word_out    <= next_wr_word_out;
            rd_valid_out   <= next_rd_valid_out;
            rd_word_out    <= next_rd_word_out;
            cmd_valid_out  <= next_cmd_valid_out;
            cmd_byte_out   <= next_cmd_byte_out;
            stat_valid_out <= next_stat_valid_out;
            stat_byte_out  <= next_stat_byte_out;
        end
    end

    // ---------------- checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    base_load_a: assert property (
        (ce && state == SFBO_IDLE && txn_start) |=> (buf_addr == $past(base) && busy)
    ) else $error("buffer address not loaded from base at start");

    addr_step_a: assert property (
        (ce && state == SFBO_ACTIVE && word_step) |=> (buf_addr == $past(buf_addr) + 32'h00000004)
    ) else $error("buffer address did not advance by one word");

    wr_lsb_little_a: assert property (
        (ce && wr_valid_in && active_cfg.wdata_lsb_first && active_cfg.byte_order_select)
        |=> (wr_valid_out && wr_word_out[31:24] == sfbo_rev8($past(wr_word_in[7:0])))
    ) else $error("write byte not reversed and swapped");

    rd_plain_a: assert property (
        (ce && rd_valid_in && !active_cfg.rdata_flip && !active_cfg.byte_order_select)
        |=> (rd_word_out == $past(rd_word_in))
    ) else $error("read word altered with ordering off");

    rd_flip_a: assert property (
        (ce && rd_valid_in && active_cfg.rdata_flip && active_cfg.byte_order_select)
        |=> (rd_word_out[7:0] == sfbo_rev8($past(rd_word_in[31:24])))
    ) else $error("read byte not flipped into little-endian place");

    cmd_order_a: assert property (
        (ce && cmd_valid_in && !active_cfg.cmd_lsb_first) |=> (cmd_byte_out == $past(cmd_byte_in))
    ) else $error("command byte changed with msb-first order");

    stat_flip_a: assert property (
        (ce && stat_valid_in && active_cfg.status_byte_bit_flip)
        |=> (stat_byte_out == sfbo_rev8($past(stat_byte_in)))
    ) else $error("status byte not reversed");

    cfg_hold_a: assert property (
        (state == SFBO_ACTIVE && !(ce && txn_done)) |=> $stable(active_cfg)
    ) else $error("active controls changed during a transaction");

    cfg_snap_a: assert property (
        (ce && state == SFBO_IDLE && txn_start) |=> (active_cfg == $past(settings))
    ) else $error("controls not captured at transaction start");

endmodule // sfbo_top

// File: include/sfbo_consts.svh
// Purpose: register map, field positions and reset values of the flash bit-order slice
// Assumes: 32-bit APB byte addresses, one aligned word per register
// Notes:   included by the top module and the bench
`ifndef SFBO_CONSTS_SVH
`define SFBO_CONSTS_SVH

`define SFBO_ADDR_BASE      32'h4001201c
`define SFBO_ADDR_SETTINGS  32'h40012020
`define SFBO_ADDR_ACTIVE    32'h40012030

`define SFBO_SETTINGS_W     9
`define SFBO_SETTINGS_RST   9'h103
`define SFBO_BASE_RST       32'h00000000

`define SFBO_BIT_WDATA_LSB  8
`define SFBO_BIT_TUNE_HI    7
`define SFBO_BIT_TUNE_LO    4
`define SFBO_BIT_STAT_FLIP  3
`define SFBO_BIT_RDATA_FLIP 2
`define SFBO_BIT_CMD_LSB    1
`define SFBO_BIT_BYTE_ORDER 0
`define SFBO_BIT_BUSY       31

`define SFBO_WORD_STEP      32'h00000004

`endif

// File: include/sfbo_pkg.sv
// Purpose: shared types and bit helpers of the flash bit-order slice
// Assumes: field layout as in sfbo_consts.svh
// Notes:   settings struct packs bits 8:0 of the settings register
package sfbo_pkg;

    typedef enum logic {
        SFBO_IDLE,
        SFBO_ACTIVE
    } sfbo_state_type;

    typedef struct packed {
        logic       wdata_lsb_first;
        logic [3:0] tune;
        logic       status_byte_bit_flip;
        logic       rdata_flip;
        logic       cmd_lsb_first;
        logic       byte_order_select;
    } sfbo_cfg_type;

    typedef enum logic [1:0] {
        SFBO_REG_NONE,
        SFBO_REG_BASE,
        SFBO_REG_SETTINGS,
        SFBO_REG_ACTIVE
    } sfbo_reg_type;

    function automatic logic [7:0] sfbo_rev8(input logic [7:0] b);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = b[7-i];
        end
        return r;
    endfunction

endpackage

// File: include/sfbo_word_if.sv
// Purpose: carries one word and its ordering controls to a byte lane mapper
// Assumes: purely combinational path
// Notes:   wire order is byte 31:24 first, bit 7 of each byte first
`timescale 1ns/1ps
interface sfbo_word_if;
    logic [31:0] word_in;
    logic        flip;
    logic        swap;
    logic [31:0] word_out;

    modport lane (input word_in, input flip, input swap, output word_out);
    modport user (output word_in, output flip, output swap, input word_out);
endinterface

// File: logic/sfbo_lane.sv
// Purpose: reorders the bytes of a word and reverses bits inside each byte
// Assumes: controls already held stable by the caller
// Notes:   per-byte flip and byte swap commute, so one mapper serves both directions
`timescale 1ns/1ps
module sfbo_lane (
    sfbo_word_if.lane wd
);
    import sfbo_pkg::*;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_byte
            logic [7:0] src;
            assign src = wd.swap ? wd.word_in[8*(3-g) +: 8] : wd.word_in[8*g +: 8];
            assign wd.word_out[8*g +: 8] = wd.flip ? sfbo_rev8(src) : src;
        end
    endgenerate

endmodule // sfbo_lane

// File: verification/sfbo_flash_model.sv
// Purpose: flash side of the read and status paths
// Assumes: one word and one status byte per call, in wire order
// Notes:   released lines show the inverse of the last value
`timescale 1ns/1ps
module sfbo_flash_model (
    input  wire logic        clk_sys,
    output logic             rd_valid,
    output logic      [31:0] rd_word,
    output logic             stat_valid,
    output logic      [7:0]  stat_byte
);
    initial begin
        rd_valid   = 1'b0;
        rd_word    = 32'h0;
        stat_valid = 1'b0;
        stat_byte  = 8'h0;
    end
    // inverse after release, so a stale capture never matches by luck
    task automatic emit(input logic [31:0] w, input logic [7:0] s);
        rd_valid   <= 1'b1;
        rd_word    <= w;
        stat_valid <= 1'b1;
        stat_byte  <= s;
        @(posedge clk_sys);
        rd_valid   <= 1'b0;
        rd_word    <= ~w;
        stat_valid <= 1'b0;
        stat_byte  <= ~s;
    endtask
endmodule // sfbo_flash_model

// File: verification/serial_flash_bit_order_config_tb.sv
// Purpose: self-checking bench of the flash bit-order slice
// Assumes: one wait state per apb access, ce held high except during the frozen-enable start strobe check
// Notes:   random data from a fixed seed, every order setting walked
`timescale 1ns/1ps
`include "sfbo_consts.svh"
module serial_flash_bit_order_config_tb;
    import sfbo_pkg::*;
    logic         clk_sys = 1'b0;
    logic         rst_n = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic  [31:0] paddr = 32'h0;
    logic  [31:0] pwdata = 32'h0;
    logic         txn_start = 1'b0;
    logic         txn_done = 1'b0;
    logic         word_step = 1'b0;
    logic         wr_valid_in = 1'b0;
    logic  [31:0] wr_word_in = 32'h0;
    logic         cmd_valid_in = 1'b0;
    logic  [7:0]  cmd_byte_in = 8'h0;
    logic         ce = 1'b1;
    logic  [3:0]  pstrb = 4'hf;
    logic  [31:0] prdata, buf_addr, rd_word_in, wr_word_out, rd_word_out;
    logic         pready, pslverr, busy, rd_valid_in, stat_valid_in;
    logic         wr_valid_out, rd_valid_out, cmd_valid_out, stat_valid_out;
    logic  [7:0]  stat_byte_in, cmd_byte_out, stat_byte_out;
    sfbo_cfg_type active_cfg;
    int           err_total = 0;
    int           cmp_count = 0;

    always #5 clk_sys = ~clk_sys;

    sfbo_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txn_start(txn_start), .txn_done(txn_done),
        .word_step(word_step), .busy(busy), .buf_addr(buf_addr), .active_cfg(active_cfg),
        .wr_valid_in(wr_valid_in), .wr_word_in(wr_word_in), .wr_valid_out(wr_valid_out),
        .wr_word_out(wr_word_out), .rd_valid_in(rd_valid_in), .rd_word_in(rd_word_in),
        .rd_valid_out(rd_valid_out), .rd_word_out(rd_word_out), .cmd_valid_in(cmd_valid_in),
        .cmd_byte_in(cmd_byte_in), .cmd_valid_out(cmd_valid_out), .cmd_byte_out(cmd_byte_out),
        .stat_valid_in(stat_valid_in), .stat_byte_in(stat_byte_in),
        .stat_valid_out(stat_valid_out), .stat_byte_out(stat_byte_out));

    sfbo_flash_model i_flash (.clk_sys(clk_sys), .rd_valid(rd_valid_in), .rd_word(rd_word_in),
        .stat_valid(stat_valid_in), .stat_byte(stat_byte_in));

    function automatic logic [7:0] rv(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rv[i] = b[7-i];
    endfunction
    function automatic logic [31:0] bsw(input logic [31:0] w);
        return {w[7:0], w[15:8], w[23:16], w[31:24]};
    endfunction
    function automatic logic [31:0] flp(input logic [31:0] w);
        return {rv(w[31:24]), rv(w[23:16]), rv(w[15:8]), rv(w[7:0])};
    endfunction

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // no cycle count assumed here; only the watchdog ends a hung wait
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // k: 2 start, 1 word step, 0 done
    task automatic strobe(input int k);
        @(posedge clk_sys);
        {txn_start, word_step, txn_done} <= 3'(3'b001 << k);
        @(posedge clk_sys);
        {txn_start, word_step, txn_done} <= 3'b000;
        @(posedge clk_sys);
    endtask

    task automatic xfer(input logic [8:0] s);
        logic [31:0] w, r, ew, er;
        logic [7:0]  c, t;
        w = $urandom;
        r = $urandom;
        c = 8'($urandom);
        t = 8'($urandom);
        ew = s[0] ? bsw(w) : w;
        ew = s[8] ? flp(ew) : ew;
        er = s[2] ? flp(r) : r;
        er = s[0] ? bsw(er) : er;
        @(posedge clk_sys);
        wr_valid_in  <= 1'b1;
        wr_word_in   <= w;
        cmd_valid_in <= 1'b1;
        cmd_byte_in  <= c;
        i_flash.emit(r, t);
        wr_valid_in  <= 1'b0;
        cmd_valid_in <= 1'b0;
        @(posedge clk_sys);
        chk(32'({wr_valid_out, rd_valid_out, cmd_valid_out, stat_valid_out}), 32'hf);
        chk(wr_word_out, ew);
        chk(rd_word_out, er);
        chk(32'(cmd_byte_out), 32'(s[1] ? rv(c) : c));
        chk(32'(stat_byte_out), 32'(s[3] ? rv(t) : t));
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        give_verdict;
    end

    initial begin
        logic [31:0] rd, base;
        logic        er;
        logic [8:0]  s;
        rd = $urandom(32'h15165b26);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        chk(32'(active_cfg), 32'h103);
        apb(1'b0, `SFBO_ADDR_SETTINGS, 32'h0, rd, er);
        chk(rd, 32'h103);
        apb(1'b0, `SFBO_ADDR_BASE, 32'h0, rd, er);
        chk(rd, 32'h0);
        apb(1'b0, 32'h40012024, 32'h0, rd, er);
        chk(32'(er), 32'h1);
        chk(rd, 32'h0);
        // frozen clock enable must ignore a start strobe
        ce <= 1'b0;
        strobe(2);
        chk(32'(busy), 32'h0);
        chk(buf_addr, 32'h0);
        ce <= 1'b1;
        base = $urandom & 32'hfffffffc;
        apb(1'b1, `SFBO_ADDR_BASE, base, rd, er);
        apb(1'b0, `SFBO_ADDR_BASE, 32'h0, rd, er);
        chk(rd, base);
        // one byte lane only: the other three bytes must keep their value
        pstrb <= 4'h2;
        apb(1'b1, `SFBO_ADDR_BASE, ~base, rd, er);
        pstrb <= 4'hf;
        base[15:8] = ~base[15:8];
        apb(1'b0, `SFBO_ADDR_BASE, 32'h0, rd, er);
        chk(rd, base);
        strobe(2);
        chk(32'(busy), 32'h1);
        chk(buf_addr, base);
        // a second start while busy must not reload the pointer
        apb(1'b1, `SFBO_ADDR_BASE, ~base, rd, er);
        strobe(2);
        strobe(1);
        strobe(1);
        chk(buf_addr, base + 32'h8);
        strobe(0);
        chk(32'(busy), 32'h0);
        for (int i = 0; i < 32; i++) begin
            s = {i[4], 4'h0, i[3:0]};
            apb(1'b1, `SFBO_ADDR_SETTINGS, 32'(s), rd, er);
            strobe(2);
            chk(32'(active_cfg), 32'(s));
            xfer(s);
            strobe(0);
        end
        s = 9'h00a;
        apb(1'b1, `SFBO_ADDR_SETTINGS, 32'(s), rd, er);
        strobe(2);
        apb(1'b1, `SFBO_ADDR_SETTINGS, 32'(s ^ 9'h105), rd, er);
        xfer(s);
        chk(32'(active_cfg), 32'(s));
        apb(1'b0, `SFBO_ADDR_ACTIVE, 32'h0, rd, er);
        chk(rd, {1'b1, 22'h0, s});
        strobe(0);
        give_verdict;
    end
endmodule // serial_flash_bit_order_config_tb
